// File: rtl/mmjio_regs.vh
`ifndef MMJIO_REGS_VH
`define MMJIO_REGS_VH
// ----------------------------------------
// opcode classes
// ----------------------------------------
`define MMJIO_OP_W              3
`define MMJIO_OP_NONE           3'h0
`define MMJIO_OP_INC_ACC        3'h1
`define MMJIO_OP_BRANCH         3'h2
`define MMJIO_OP_MOVE_MEM       3'h3
`define MMJIO_OP_MOVE_IMM       3'h4
// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define MMJIO_DATA_W            8
`define MMJIO_ADDR_W            7
`define MMJIO_PC_W              11
`define MMJIO_ACC_RST           8'h00
`define MMJIO_PC_RST            11'h000
`define MMJIO_FLAG_RST          1'h0
`define MMJIO_ZERO_BYTE         8'h00
`define MMJIO_ONE_BYTE          8'h01
`define MMJIO_PC_ONE            11'h001
`endif

// File: rtl/mmjio_mem.v
`timescale 1ns/1ps
`include "mmjio_regs.vh"
// small data memory; read data registered, so an operand is
// presented one cycle after its address
module mmjio_mem #(
    parameter AW = `MMJIO_ADDR_W,
    parameter DW = `MMJIO_DATA_W
) (
    input  wire          sys_clk,
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data_q,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule // mmjio_mem

// File: rtl/mmjio_exec.v
`timescale 1ns/1ps
`include "mmjio_regs.vh"
// Summary of operation
// RULE1 - increment_to_accumulator loads byte+1, memory kept, zero on sum.
// RULE2 - unconditional_branch loads pc with the target; no flag changes.
// RULE3 - unconditional_branch takes two cycles, the second a dummy slot.
// RULE4 - move_op from memory copies the byte and leaves all flags alone.
// RULE5 - move_op immediate writes the 8-bit immediate into the accumulator.
// RULE6 - increment and move instructions each complete in one cycle.
module mmjio_exec #(
    parameter AW = `MMJIO_ADDR_W,
    parameter DW = `MMJIO_DATA_W,
    parameter PW = `MMJIO_PC_W
) (
    input  wire                    sys_clk,
    input  wire                    rst_b,
    input  wire                    instr_valid,
    input  wire [`MMJIO_OP_W-1:0]  instr_op,
    input  wire [AW-1:0]           instr_mem_addr,
    input  wire [DW-1:0]           instr_imm,
    input  wire [PW-1:0]           instr_target,
    input  wire                    mem_wr_en,
    input  wire [AW-1:0]           mem_wr_addr,
    input  wire [DW-1:0]           mem_wr_data,
    output wire                    instr_ready,
    output reg  [DW-1:0]           accumulator_q,
    output reg  [PW-1:0]           pc_q,
    output reg                     zero_flag_q,
    output reg                     dummy_slot_q,
    output reg                     done_q
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    // one-hot codes; only the fetch state accepts a new instruction
    localparam [2:0] ST_FETCH = 3'h1;
    localparam [2:0] ST_EXEC  = 3'h2;
    localparam [2:0] ST_DUMMY = 3'h4;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg  [2:0]             state_q;
    reg  [2:0]             state_d;
    reg  [`MMJIO_OP_W-1:0] op_q;
    reg  [`MMJIO_OP_W-1:0] op_d;
    reg  [DW-1:0]          imm_q;
    reg  [DW-1:0]          imm_d;
    reg  [PW-1:0]          target_q;
    reg  [PW-1:0]          target_d;
    reg  [DW-1:0]          accumulator_d;
    reg  [PW-1:0]          pc_d;
    reg                    zero_flag_d;
    reg                    dummy_slot_d;
    reg                    done_d;
    wire [DW-1:0]          mem_rd_data;
    wire [DW-1:0]          inc_sum;
    wire                   take;
    wire                   in_exec;
    wire                   in_dummy;

    // ----------------------------------------
    // arithmetic helpers
    // ----------------------------------------
    function [DW-1:0] inc_byte;
        input [DW-1:0] v;
        begin
            inc_byte = v + `MMJIO_ONE_BYTE;
        end
    endfunction

    // wraps at the top of program space: the carry is dropped on purpose
    function [PW-1:0] step_pc;
        input [PW-1:0] v;
        begin
            step_pc = v + `MMJIO_PC_ONE;
        end
    endfunction

    function is_zero;
        input [DW-1:0] v;
        begin
            is_zero = (v == `MMJIO_ZERO_BYTE);
        end
    endfunction

    // ----------------------------------------
    // operand memory
    // ----------------------------------------
    // the execute logic only reads memory; writes reach it straight from the mem_wr_en, mem_wr_addr and mem_wr_data ports
    mmjio_mem #(.AW(AW), .DW(DW)) u_mem (
        .sys_clk   (sys_clk),
        .rd_addr   (instr_mem_addr),
        .rd_data_q (mem_rd_data),
        .wr_en     (mem_wr_en),
        .wr_addr   (mem_wr_addr),
        .wr_data   (mem_wr_data)
    );

    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign take        = instr_valid && (state_q == ST_FETCH);
    assign in_exec     = (state_q == ST_EXEC);
    assign in_dummy    = (state_q == ST_DUMMY);
    assign instr_ready = (state_q == ST_FETCH);
    assign inc_sum     = inc_byte(mem_rd_data); // RULE1

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_FETCH: begin
                if (instr_valid) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (op_q == `MMJIO_OP_BRANCH) begin
                    state_d = ST_DUMMY; // RULE3
                end else begin
                    state_d = ST_FETCH; // RULE6
                end
            end
            ST_DUMMY: begin
                state_d = ST_FETCH;
            end
            default: begin
                state_d = ST_FETCH;
            end
        endcase
    end

    // ----------------------------------------
    // instruction latch
    // ----------------------------------------
    // the operand address is not held here: the memory samples it
    // at the take edge, which saves a register stage of latency
    always @* begin
        op_d     = op_q;
        imm_d    = imm_q;
        target_d = target_q;
        if (take) begin
            op_d     = instr_op;
            imm_d    = instr_imm;
            target_d = instr_target;
        end
    end

    // ----------------------------------------
    // execute
    // ----------------------------------------
    always @* begin
        accumulator_d = accumulator_q;
        pc_d          = pc_q;
        zero_flag_d   = zero_flag_q;
        dummy_slot_d  = 1'h0;
        done_d        = 1'h0;
        if (in_exec) begin
            case (op_q)
                `MMJIO_OP_INC_ACC: begin
                    accumulator_d = inc_sum; // RULE1
                    zero_flag_d   = is_zero(inc_sum); // RULE1
                    pc_d          = step_pc(pc_q);
                    done_d        = 1'h1; // RULE6
                end
                `MMJIO_OP_BRANCH: begin
                    // flags deliberately untouched; completion waits
                    // until the dummy slot has passed
                    pc_d         = target_q; // RULE2
                    dummy_slot_d = 1'h1; // RULE3
                end
                `MMJIO_OP_MOVE_MEM: begin
                    accumulator_d = mem_rd_data; // RULE4
                    pc_d          = step_pc(pc_q);
                    done_d        = 1'h1; // RULE6
                end
                `MMJIO_OP_MOVE_IMM: begin
                    accumulator_d = imm_q; // RULE5
                    pc_d          = step_pc(pc_q);
                    done_d        = 1'h1; // RULE6
                end
                default: begin
                    // other classes belong elsewhere; just step
                    pc_d   = step_pc(pc_q);
                    done_d = 1'h1;
                end
            endcase
        end
        if (in_dummy) begin
            done_d = 1'h1; // RULE3
        end
    end

    // ----------------------------------------
    // sequencer and latch registers
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q  <= ST_FETCH;
            op_q     <= `MMJIO_OP_NONE;
            imm_q    <= `MMJIO_ZERO_BYTE;
            target_q <= `MMJIO_PC_RST;
        end else begin
            state_q  <= state_d;
            op_q     <= op_d;
            imm_q    <= imm_d;
            target_q <= target_d;
        end
    end

    // ----------------------------------------
    // architectural registers
    // ----------------------------------------
    // the zero flag has no other writer in this block, so a move or a
    // branch simply keeps whatever the last increment left there
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            accumulator_q <= `MMJIO_ACC_RST;
            pc_q          <= `MMJIO_PC_RST;
            zero_flag_q   <= `MMJIO_FLAG_RST;
        end else begin
            accumulator_q <= accumulator_d;
            pc_q          <= pc_d;
            zero_flag_q   <= zero_flag_d;
        end
    end

    // ----------------------------------------
    // completion pulses
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dummy_slot_q <= `MMJIO_FLAG_RST;
            done_q       <= `MMJIO_FLAG_RST;
        end else begin
            dummy_slot_q <= dummy_slot_d;
            done_q       <= done_d;
        end
    end
endmodule // mmjio_exec

// File: bench/mmjio_checker.sv
`timescale 1ns/1ps
module mmjio_checker (
    input wire        sys_clk,
    input wire        rst_b,
    input wire        instr_valid,
    input wire [2:0]  instr_op,
    input wire [7:0]  instr_imm,
    input wire [10:0] instr_target,
    input wire        instr_ready,
    input wire [7:0]  accumulator_q,
    input wire [10:0] pc_q,
    input wire        zero_flag_q,
    input wire        dummy_slot_q,
    input wire        done_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire tk = instr_valid && instr_ready;
    property p_inc; tk && instr_op == 3'h1 |-> ##2 done_q
        && zero_flag_q == (accumulator_q == 8'h00); endproperty
    a_inc: assert property (p_inc) else $error("inc zero");
    property p_br; tk && instr_op == 3'h2 |-> ##2 dummy_slot_q && !done_q
        && pc_q == $past(instr_target, 2) ##1 done_q; endproperty
    a_br: assert property (p_br) else $error("branch");
    property p_brz; tk && instr_op == 3'h2 |->
        ##1 $stable(zero_flag_q) [*3]; endproperty
    a_brz: assert property (p_brz) else $error("branch flag");
    property p_mov; tk && instr_op == 3'h3 |->
        ##1 $stable(zero_flag_q) [*2] ##0 done_q; endproperty
    a_mov: assert property (p_mov) else $error("move flag");
    property p_imm; tk && instr_op == 3'h4 |-> ##2 done_q
        && accumulator_q == $past(instr_imm, 2); endproperty
    a_imm: assert property (p_imm) else $error("move imm");
    property p_dum; dummy_slot_q |=> done_q; endproperty
    a_dum: assert property (p_dum) else $error("dummy slot");
    c_inc: cover property (tk && instr_op == 3'h1);
    c_br: cover property (dummy_slot_q);
    c_mov: cover property (tk && instr_op == 3'h3);
    c_imm: cover property (tk && instr_op == 3'h4);
endmodule // mmjio_checker
bind mmjio_exec mmjio_checker mmjio_checker_i (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .instr_valid   (instr_valid),
    .instr_op      (instr_op),
    .instr_imm     (instr_imm),
    .instr_target  (instr_target),
    .instr_ready   (instr_ready),
    .accumulator_q (accumulator_q),
    .pc_q          (pc_q),
    .zero_flag_q   (zero_flag_q),
    .dummy_slot_q  (dummy_slot_q),
    .done_q        (done_q)
);

// File: bench/test_mcu_move_jump_increment_ops.sv
`timescale 1ns/1ps
module test_mcu_move_jump_increment_ops;
    reg        sys_clk = 0, rst_b = 0, instr_valid = 0, mem_wr_en = 0;
    reg [2:0]  instr_op = 0;
    reg [6:0]  instr_mem_addr = 0, mem_wr_addr = 0;
    reg [7:0]  instr_imm = 0, mem_wr_data = 0;
    reg [10:0] instr_target = 0;
    wire       instr_ready, zero_flag_q, dummy_slot_q, done_q;
    wire [7:0] accumulator_q;
    wire [10:0] pc_q;
    int failures = 0, cmp_count = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    mmjio_exec mmjio_exec_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_mem_addr(instr_mem_addr), .instr_imm(instr_imm),
        .instr_target(instr_target), .mem_wr_en(mem_wr_en),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .instr_ready(instr_ready), .accumulator_q(accumulator_q),
        .pc_q(pc_q), .zero_flag_q(zero_flag_q),
        .dummy_slot_q(dummy_slot_q), .done_q(done_q));
    task chk(input logic [10:0] s, e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask
    // negedges from presenting a request to seeing done_q, take included
    localparam int LAT_ONE = 2;
    localparam int LAT_BR  = 3;
    task wrap_up;
        $display("failures %0d cmp_count %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one write strobe, then an idle edge before the next request
    task wr(input [6:0] a, input [7:0] d);
        @(negedge sys_clk);
        mem_wr_en   = 1'h1;
        mem_wr_addr = a;
        mem_wr_data = d;
        @(negedge sys_clk);
        mem_wr_en = 1'h0;
    endtask
    // address held until the next request: operand read lags the take
    task run(input [2:0] op, input [6:0] a, input [7:0] x,
             input [10:0] t, input int n);
        int k;
        int d;
        @(negedge sys_clk);
        {instr_valid, instr_op} = {1'h1, op};
        {instr_mem_addr, instr_imm, instr_target} = {a, x, t};
        @(negedge sys_clk);
        instr_valid = 1'h0;
        k = 1;
        d = 0;
        while (done_q !== 1'h1 && k < 9) begin
            @(negedge sys_clk);
            k++;
            if (dummy_slot_q === 1'h1) begin
                d++;
            end
        end
        chk(11'(k), 11'(n));
        chk(11'(d), 11'(op == 3'h2));
    endtask
    task t_inc_move;
        wr(7'h12, 8'hff);
        wr(7'h40, 8'h05);
        wr(7'h41, 8'h00);
        run(3'h1, 7'h12, 8'h00, 11'h000, LAT_ONE);
        chk(accumulator_q, 8'h00);
        chk(zero_flag_q, 1'h1);
        run(3'h3, 7'h12, 8'h00, 11'h000, LAT_ONE);
        chk(accumulator_q, 8'hff);
        chk(zero_flag_q, 1'h1);
        run(3'h1, 7'h40, 8'h00, 11'h000, LAT_ONE);
        chk(accumulator_q, 8'h06);
        chk(zero_flag_q, 1'h0);
        run(3'h3, 7'h40, 8'h00, 11'h000, LAT_ONE);
        chk(accumulator_q, 8'h05);
        run(3'h3, 7'h41, 8'h00, 11'h000, LAT_ONE);
        chk(accumulator_q, 8'h00);
        chk(zero_flag_q, 1'h0);
        run(3'h4, 7'h00, 8'h5a, 11'h000, LAT_ONE);
        chk(accumulator_q, 8'h5a);
    endtask
    // zero is set first so that a branch which disturbed it would show
    task t_branch;
        run(3'h1, 7'h12, 8'h00, 11'h000, LAT_ONE);
        run(3'h2, 7'h00, 8'h00, 11'h7ff, LAT_BR);
        chk(pc_q, 11'h7ff);
        chk(zero_flag_q, 1'h1);
        chk(accumulator_q, 8'h00);
        run(3'h2, 7'h00, 8'h00, 11'h123, LAT_BR);
        chk(pc_q, 11'h123);
        run(3'h4, 7'h00, 8'ha5, 11'h000, LAT_ONE);
        chk(pc_q, 11'h124);
        chk(accumulator_q, 8'ha5);
    endtask
    // a reset in mid-run returns every output to its idle value
    task t_reset;
        @(negedge sys_clk);
        rst_b = 1'h0;
        @(negedge sys_clk);
        chk(accumulator_q, 8'h00);
        chk(pc_q, 11'h000);
        chk(zero_flag_q, 1'h0);
        chk(done_q, 1'h0);
        chk(instr_ready, 1'h1);
        rst_b = 1'h1;
        run(3'h4, 7'h00, 8'h3c, 11'h000, LAT_ONE);
        chk(accumulator_q, 8'h3c);
    endtask
    // a hang is cut short well above the fifty or so cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            wrap_up;
        end
    end
    initial begin
        repeat (10) @(negedge sys_clk);
        rst_b = 1'h1;
        chk(instr_ready, 1'h1);
        t_inc_move;
        t_branch;
        t_reset;
        wrap_up;
    end
endmodule // test_mcu_move_jump_increment_ops
